// [rtl/usc_pkg.sv]
// usc_pkg: register map, field positions, reset values and carriers of the serial transceiver core.
// assumes one 100 MHz system clock and a byte-wide register port with one-cycle read latency.
package usc_pkg;
  // register offsets on the byte-wide port
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_STAT_A = 3'h1;
  localparam logic [2:0] OFF_CTRL_B = 3'h2;
  localparam logic [2:0] OFF_CTRL_C = 3'h3;
  localparam logic [2:0] OFF_BAUD_LO = 3'h4;
  localparam logic [2:0] OFF_BAUD_HI = 3'h5;
  localparam logic [2:0] OFF_POWER = 3'h6;
  localparam logic [2:0] OFF_PIN_CTRL = 3'h7;
  // ctrl_status_a fields
  localparam int A_RXC = 7, A_TXC = 6, A_UDRE = 5, A_FE = 4, A_DOR = 3, A_PE = 2, A_U2X = 1, A_MPCM = 0;
  // ctrl_status_b fields
  localparam int B_RXCIE = 7, B_TXCIE = 6, B_UDRIE = 5, B_RXEN = 4, B_TXEN = 3, B_SIZE2 = 2, B_RXB8 = 1, B_TXB8 = 0;
  // ctrl_status_c fields (mode is two bits at 7:6, parity at 5:4, size low bits at 2:1)
  localparam int C_MODE = 6, C_PAR = 4, C_STOP2 = 3, C_SIZE = 1, C_CPOL = 0;
  // power_reduction_reg and pin control fields
  localparam int P_PWR = 0;
  localparam int X_DIR = 0, X_SFDEN = 1, X_SFD = 2;
  // sync_mode_select codes
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_SPI = 2'h3;
  // reset values: async normal speed, 8-bit characters, everything off
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] CTRL_C_RST = 8'h06;
  localparam logic POWER_RST = 1'b0;
  // oversampling counts
  localparam logic [3:0] PRE_TOP_NORM = 4'hF;
  localparam logic [3:0] PRE_TOP_DBL = 4'h7;
  localparam logic [3:0] MAJ_NORM = 4'h9;
  localparam logic [3:0] MAJ_DBL = 4'h5;
  // character size coding
  localparam logic [2:0] SIZE9 = 3'h7;
  localparam logic [3:0] NBITS_BASE = 4'h5;
  localparam logic [3:0] NBITS_NINE = 4'h9;
  localparam logic [3:0] SPI_BITS = 4'h8;
  localparam int BAUD_W_DEF = 12;
  localparam int FRAME_W = 13;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } usc_bus_t;

  typedef struct packed {
    logic [8:0] data;
    logic fe;
    logic pe;
  } usc_rx_ent_t;

  typedef enum logic [0:0] {USC_RX_IDLE, USC_RX_BODY} usc_rx_state_t;
endpackage

// [rtl/usc_core.sv]
// usc_core: serial transceiver with baud generator, async/sync/spi clocking, tx buffer and 2-deep rx queue.
// assumes a single-cycle register port on mclk; pins are resynchronised here.
//
// How it works
// - four clock modes: async, double, master, slave
// - mode bit 0 selects async or sync
// - double speed only affects async timing
// - sync: pin direction picks master or slave
// - transfer clock pin idle in async modes
// - baud generator plus synchroniser for external clock
// - one buffered character allows gapless frames
// - two-deep receive queue behind shifter
// - flags framing, overrun and parity errors
// - receiver accepts every transmitter frame format
// - async receive uses oversampled clock/data recovery
// - three separately enabled interrupt requests
// - five to nine data bits, 1-2 stops
// - hardware odd/even parity generate and check
// - false start rejection and majority filter
// - master spi mode offered
// - one shared register set configures everything
// - multiprocessor, double speed, start frame detection
// - down-counter reloads at zero or low write
// - polarity picks change and sample edges
// - start low, lsb first, parity, stops high
// - parity is xor of data, odd inverts
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module usc_core
  import usc_pkg::*;
#(
  parameter int DIV_W = BAUD_W_DEF
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire usc_bus_t bus,
  output logic [7:0] rdata,
  output logic serial_out_line,
  output logic serial_out_oe,
  input wire logic serial_in_line,
  output logic xck_out,
  output logic xck_oe,
  input wire logic xck_in,
  output logic irq_rx,
  output logic irq_tx,
  output logic irq_udre
);
  if (DIV_W < 9 || DIV_W > 16) begin : g_chk
    $error("usc_core: DIV_W must be 9..16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and decode
  logic serial_unit_power_off, run;
  logic rxcie, txcie, udrie, rxen, txen, size2, txb8, double_speed_bit, mpcm;
  logic [1:0] sync_mode_select, par_mode, size10;
  logic stop2, clock_polarity_select, transfer_clock_direction, sfd_en, sfd_flag, txc, dor;
  logic [DIV_W-1:0] baud_divisor, bcnt;
  logic btick;
  logic wr_data, wr_a, wr_lo, rd_data;

  assign run = ~serial_unit_power_off;
  assign wr_data = bus.wr && bus.addr == OFF_DATA;
  assign wr_a = bus.wr && bus.addr == OFF_STAT_A;
  assign wr_lo = bus.wr && bus.addr == OFF_BAUD_LO;
  assign rd_data = bus.rd && bus.addr == OFF_DATA;

  // one shared control set for clock, tx and rx; defaults give async normal speed, all disabled
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      {rxcie, txcie, udrie, rxen, txen, size2} <= CTRL_B_RST[7:2];
      txb8 <= CTRL_B_RST[B_TXB8];
      {sync_mode_select, par_mode, stop2, size10, clock_polarity_select} <= CTRL_C_RST;
      {double_speed_bit, mpcm, transfer_clock_direction, sfd_en} <= 4'h0;
      serial_unit_power_off <= POWER_RST;
      baud_divisor <= '0;
    end else if (bus.wr) begin
      case (bus.addr)
        OFF_STAT_A: {double_speed_bit, mpcm} <= {bus.wdata[A_U2X], bus.wdata[A_MPCM]};
        OFF_CTRL_B: begin
          {rxcie, txcie, udrie, rxen, txen, size2} <= bus.wdata[7:2];
          txb8 <= bus.wdata[B_TXB8];
        end
        OFF_CTRL_C: {sync_mode_select, par_mode, stop2, size10, clock_polarity_select} <= bus.wdata;
        OFF_BAUD_LO: baud_divisor[7:0] <= bus.wdata;
        OFF_BAUD_HI: baud_divisor[DIV_W-1:8] <= bus.wdata[DIV_W-9:0];
        OFF_POWER: serial_unit_power_off <= bus.wdata[P_PWR];
        OFF_PIN_CTRL: {sfd_en, transfer_clock_direction} <= {bus.wdata[X_SFDEN], bus.wdata[X_DIR]};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud generator: down-counter on the system clock, one tick per reload at zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bcnt <= '0;
      btick <= 1'b0;
    end else if (run) begin
      btick <= bcnt == '0;
      if (wr_lo) bcnt <= {baud_divisor[DIV_W-1:8], bus.wdata};
      else if (bcnt == '0) bcnt <= baud_divisor;
      else bcnt <= bcnt - 1'b1;
    end else begin
      btick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock mode selection and transfer clock edges
  logic is_sync, is_spi, is_master, xs1, xs2, xs3, rs1, rs2;
  logic pin_rise, pin_fall, chg_edge, smp_edge;
  assign is_sync = sync_mode_select[0];
  assign is_spi = sync_mode_select == MODE_SPI;
  assign is_master = is_sync && transfer_clock_direction;

  // two-stage synchronisers; the third stage only feeds the slave edge detector
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      {xs1, xs2, xs3} <= 3'h7; // idle-high clock pin: no false edge after reset
      {rs1, rs2} <= 2'h3;
    end else begin
      {xs1, xs2, xs3} <= {xck_in, xs1, xs2};
      {rs1, rs2} <= {serial_in_line, rs1};
    end
  end

  // master drives the clock at half the tick rate; async leaves the pin alone
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      xck_out <= 1'b0;
      xck_oe <= 1'b0;
    end else begin
      xck_oe <= run && is_master;
      if (run && is_master && btick) xck_out <= ~xck_out;
    end
  end

  // polarity clear: change on rising, sample on falling
  assign pin_rise = is_master ? (btick && !xck_out) : (xs2 && !xs3);
  assign pin_fall = is_master ? (btick && xck_out) : (!xs2 && xs3);
  assign chg_edge = run && is_sync && (clock_polarity_select ? pin_fall : pin_rise);
  assign smp_edge = run && is_sync && (clock_polarity_select ? pin_rise : pin_fall);

  ////////////////////////////////////////////////////////////////////////////
  // frame format shared by both directions
  logic [3:0] nbits, frame_len, tx_left, tx_pre, last_idx;
  logic [8:0] dmask, txbuf;
  logic par_en, tx_par, txbuf_full, tx_busy, tx_step, tx_load, tx_done;
  logic [FRAME_W-1:0] frame, tx_sh;
  assign nbits = {size2, size10} == SIZE9 ? NBITS_NINE : NBITS_BASE + {2'h0, size10};
  assign dmask = ~(9'h1FF << nbits);
  assign par_en = par_mode[1];
  assign tx_par = ^(txbuf & dmask) ^ par_mode[0];

  // start low, data lsb first, optional parity, one or two high stops
  always_comb begin
    frame = '1;
    frame_len = SPI_BITS;
    if (is_spi) begin
      frame = {5'h1F, txbuf[7:0]};
    end else begin
      frame[0] = 1'b0;
      for (int i = 0; i < 9; i++) begin
        if (i < int'(nbits)) frame[1+i] = txbuf[i];
      end
      if (par_en) frame[1+int'(nbits)] = tx_par;
      frame_len = 4'h2 + nbits + {3'h0, par_en} + {3'h0, stop2};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: async bit timing from the prescaler, sync from the change edge
  logic [3:0] pre_top;
  assign pre_top = double_speed_bit ? PRE_TOP_DBL : PRE_TOP_NORM;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_pre <= 4'h0;
    end else if (run && btick) begin
      tx_pre <= tx_pre == pre_top ? 4'h0 : tx_pre + 4'h1;
    end
  end
  // double speed is only consulted on the async path
  assign tx_step = run && (is_sync ? chg_edge : (btick && tx_pre == pre_top));
  assign tx_load = tx_step && tx_left == 4'h0 && txbuf_full && txen;
  assign tx_done = tx_step && tx_left == 4'h0 && tx_busy && !tx_load;

  // buffered character reloads the shifter on the last bit's step, so frames abut
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_sh <= '0;
      tx_left <= 4'h0;
      tx_busy <= 1'b0;
      serial_out_line <= 1'b1;
      txbuf <= 9'h0;
      txbuf_full <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= run && txen;
      if (run && wr_data && txen && !txbuf_full) begin
        txbuf <= {txb8, bus.wdata};
        txbuf_full <= 1'b1;
      end
      if (tx_step && tx_left != 4'h0) begin
        serial_out_line <= tx_sh[0];
        tx_sh <= tx_sh >> 1;
        tx_left <= tx_left - 4'h1;
      end else if (tx_load) begin
        serial_out_line <= frame[0];
        tx_sh <= frame >> 1;
        tx_left <= frame_len - 4'h1;
        tx_busy <= 1'b1;
        txbuf_full <= 1'b0;
      end else if (tx_done) begin
        serial_out_line <= 1'b1;
        tx_busy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // async recovery: 16x (8x in double speed) oversampling, 3-sample majority
  logic a_act, maj, a_pt, bit_v, bit_val, start_take, rx_done, rx_keep;
  logic [3:0] rx_pre, rx_idx;
  logic [1:0] win;
  logic [11:0] rx_sh, rx_cur;
  usc_rx_state_t rx_st;
  usc_rx_ent_t rx_ent;
  assign maj = (win[1] & win[0]) | (win[0] & rs2) | (win[1] & rs2);
  assign a_pt = btick && a_act && rx_pre == (double_speed_bit ? MAJ_DBL : MAJ_NORM);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      a_act <= 1'b0;
      rx_pre <= 4'h0;
      win <= 2'h3;
    end else if (run && btick && !is_sync && rxen) begin
      win <= {win[0], rs2};
      if (!a_act) begin
        if (!rs2) begin
          a_act <= 1'b1;
          rx_pre <= 4'h1;
        end
      end else begin
        rx_pre <= rx_pre == (double_speed_bit ? PRE_TOP_DBL : PRE_TOP_NORM) ? 4'h0 : rx_pre + 4'h1;
        if (a_pt && ((rx_st == USC_RX_IDLE && maj) || rx_done)) a_act <= 1'b0;
      end
    end else if (!rxen || is_sync) begin
      a_act <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit collector shared by async and sync reception
  assign bit_v = is_sync ? (smp_edge && rxen) : (a_pt && rxen && run);
  assign bit_val = is_sync ? rs2 : maj;
  assign start_take = bit_v && rx_st == USC_RX_IDLE && (is_spi ? tx_busy : !bit_val);
  assign last_idx = is_spi ? SPI_BITS - 4'h1 : nbits + {3'h0, par_en};
  assign rx_done = bit_v && rx_st == USC_RX_BODY && rx_idx == last_idx;

  always_comb begin
    rx_cur = rx_sh;
    rx_cur[rx_idx] = bit_val;
    rx_ent.data = rx_cur[8:0] & (is_spi ? 9'h0FF : dmask);
    rx_ent.fe = !is_spi && !rx_cur[last_idx];
    rx_ent.pe = !is_spi && par_en && (rx_cur[nbits] ^ (^rx_ent.data) ^ par_mode[0]);
    rx_keep = !(mpcm && !rx_cur[nbits - 4'h1]);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_st <= USC_RX_IDLE;
      rx_idx <= 4'h0;
      rx_sh <= 12'h0;
    end else if (!rxen) begin
      rx_st <= USC_RX_IDLE;
    end else if (bit_v) begin
      case (rx_st)
        USC_RX_IDLE: begin
          if (start_take) begin
            rx_st <= USC_RX_BODY;
            rx_sh[0] <= bit_val;
            rx_idx <= is_spi ? 4'h1 : 4'h0;
          end
        end
        USC_RX_BODY: begin
          rx_sh <= rx_cur;
          rx_idx <= rx_idx + 4'h1;
          if (rx_done) rx_st <= USC_RX_IDLE;
        end
        default: rx_st <= USC_RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-deep receive queue; a read of the data register pops the head
  usc_rx_ent_t rxq [2];
  logic rx_wp, rx_rp, pop, push, ovr;
  logic [1:0] rx_cnt;
  assign pop = rd_data && rx_cnt != 2'h0;
  assign push = rx_done && rx_keep && !(rx_cnt == 2'h2 && !pop);
  assign ovr = rx_done && rx_keep && rx_cnt == 2'h2 && !pop;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_wp <= 1'b0;
      rx_rp <= 1'b0;
      rx_cnt <= 2'h0;
      rxq[0] <= '0;
      rxq[1] <= '0;
    end else if (!rxen) begin
      rx_cnt <= 2'h0; // disabling the receiver flushes the queue
      rx_rp <= rx_wp;
    end else begin
      if (push) begin
        rxq[rx_wp] <= rx_ent;
        rx_wp <= ~rx_wp;
      end
      if (pop) rx_rp <= ~rx_rp;
      rx_cnt <= rx_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags: hardware set wins over the software clear in the same cycle
  logic sfd_hit;
  assign sfd_hit = start_take && sfd_en && !is_spi;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      txc <= 1'b0;
      dor <= 1'b0;
      sfd_flag <= 1'b0;
    end else begin
      if (tx_done) txc <= 1'b1;
      else if (wr_a && bus.wdata[A_TXC]) txc <= 1'b0;
      if (ovr) dor <= 1'b1;
      else if (rd_data) dor <= 1'b0;
      if (sfd_hit) sfd_flag <= 1'b1;
      else if (bus.wr && bus.addr == OFF_PIN_CTRL && bus.wdata[X_SFD]) sfd_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data for exactly the cycle after the strobe, and interrupt requests
  usc_rx_ent_t head;
  assign head = rxq[rx_rp];
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata <= 8'h0;
      {irq_rx, irq_tx, irq_udre} <= 3'h0;
    end else begin
      {irq_rx, irq_tx, irq_udre} <= {rxcie && rx_cnt != 2'h0, txcie && txc, udrie && !txbuf_full};
      if (!bus.rd) rdata <= 8'h0;
      else begin
        case (bus.addr)
          OFF_DATA: rdata <= head.data[7:0];
          OFF_STAT_A: rdata <= {rx_cnt != 2'h0, txc, !txbuf_full, head.fe, dor, head.pe, double_speed_bit, mpcm};
          OFF_CTRL_B: rdata <= {rxcie, txcie, udrie, rxen, txen, size2, head.data[8], txb8};
          OFF_CTRL_C: rdata <= {sync_mode_select, par_mode, stop2, size10, clock_polarity_select};
          OFF_BAUD_LO: rdata <= baud_divisor[7:0];
          OFF_BAUD_HI: rdata <= 8'(baud_divisor[DIV_W-1:8]);
          OFF_POWER: rdata <= {7'h0, serial_unit_power_off};
          OFF_PIN_CTRL: rdata <= {5'h0, sfd_flag, sfd_en, transfer_clock_direction};
          default: rdata <= 8'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_pwr_pins;
    serial_unit_power_off |=> !serial_out_oe && !xck_oe;
  endproperty
  a_pwr_pins: assert property (p_pwr_pins) else $error("pins driven while powered off");
  property p_pwr_hold;
    serial_unit_power_off && $past(serial_unit_power_off) |-> $stable(tx_left) && $stable(bcnt);
  endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("state moved while powered off");
  property p_async_xck;
    !is_sync |=> !xck_oe;
  endproperty
  a_async_xck: assert property (p_async_xck) else $error("transfer clock driven in async");
  property p_master_dir;
    run && is_sync && transfer_clock_direction |=> xck_oe;
  endproperty
  a_master_dir: assert property (p_master_dir) else $error("master clock not driven");
  property p_reload;
    run && bcnt == '0 && !wr_lo && $stable(baud_divisor) |=> btick && bcnt == $past(baud_divisor);
  endproperty
  a_reload: assert property (p_reload) else $error("baud counter reload wrong");
  property p_sync_no_u2x;
    is_sync && tx_step |-> chg_edge;
  endproperty
  a_sync_no_u2x: assert property (p_sync_no_u2x) else $error("sync step not on change edge");
  property p_start_low;
    tx_load && !is_spi |=> !serial_out_line;
  endproperty
  a_start_low: assert property (p_start_low) else $error("frame did not open low");
  property p_overrun;
    rxen && rx_cnt == 2'h2 && rx_done && rx_keep && !rd_data |=> dor && rx_cnt == 2'h2;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");
  property p_irq_rx;
    rxcie && rx_cnt != 2'h0 |=> irq_rx;
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("receive request missing");

  c_back_to_back: cover property (tx_load && tx_busy);
  c_overrun: cover property (ovr);
  c_false_start: cover property (a_pt && rx_st == USC_RX_IDLE && maj);
  c_slave_frame: cover property (rx_done && is_sync && !is_master);
endmodule
`default_nettype wire

// [dv/usc_peer.sv]
// usc_peer: remote async transceiver facing the serial pins of the core.
// assumes the bench calls its tasks from mclk-paced code; idle line is high.
`timescale 1ns/10ps
`default_nettype none
module usc_peer (
  input wire logic mclk,
  input wire logic line_from_dut,
  output logic line_to_dut
);
  initial line_to_dut = 1'b1;
  //////////////////////////////////////////////////////////////////////////////
  // one bit held for per clocks
  task automatic put_bit(input logic b, input int per);
    line_to_dut <= b;
    repeat (per) @(posedge mclk);
  endtask
  // start low, data lsb first, optional parity, one stop, then idle high
  task automatic send(input logic [8:0] d, input int nb, input logic [1:0] par, input logic stop, input int per);
    logic p;
    p = ^(d & ((9'h001 << nb) - 9'h001)) ^ par[0];
    put_bit(1'b0, per);
    for (int i = 0; i < nb; i++) put_bit(d[i], per);
    if (par[1]) put_bit(p, per);
    put_bit(stop, per);
    line_to_dut <= 1'b1;
  endtask
  // sampled on the falling clock edge so register updates have landed
  task automatic recv(output logic [8:0] d, output logic p, output logic s, output int waited, input int nb,
                      input logic haspar, input int per);
    d = 9'h000;
    p = 1'b0;
    waited = 0;
    while (line_from_dut !== 1'b0 && waited < 4000) begin
      @(negedge mclk);
      waited++;
    end
    repeat (per / 2) @(negedge mclk);
    for (int i = 0; i < nb; i++) begin
      repeat (per) @(negedge mclk);
      d[i] = line_from_dut;
    end
    if (haspar) begin
      repeat (per) @(negedge mclk);
      p = line_from_dut;
    end
    repeat (per) @(negedge mclk);
    s = line_from_dut;
  endtask
endmodule
`default_nettype wire

// [dv/tb_usc_core.sv]
// tb_usc_core: self-checking bench for usc_core with a remote peer model.
// assumes divisor 0 so one baud tick per clock; bus driven by nba on mclk.
`timescale 1ns/10ps
`default_nettype none
module tb_usc_core;
  import usc_pkg::*;
  logic mclk;
  logic sys_rst;
  usc_bus_t bus;
  logic [7:0] rdata;
  logic serial_out_line, serial_out_oe, xck_out, xck_oe, irq_rx, irq_tx, irq_udre;
  logic peer_line;
  wire logic tx_wire;
  wire logic xck_wire;
  int fail_count = 0;
  int comparisons = 0;
  logic [8:0] d0, d1;
  logic p0, s0, s1;
  int w0, w1;
  // released pins float to the pull-up level
  assign tx_wire = serial_out_oe ? serial_out_line : 1'b1;
  assign xck_wire = xck_oe ? xck_out : 1'b1;
  usc_core i_usc_core (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .serial_out_line(serial_out_line),
    .serial_out_oe(serial_out_oe), .serial_in_line(peer_line), .xck_out(xck_out), .xck_oe(xck_oe),
    .xck_in(xck_wire), .irq_rx(irq_rx), .irq_tx(irq_tx), .irq_udre(irq_udre));
  usc_peer i_usc_peer (.mclk(mclk), .line_from_dut(tx_wire), .line_to_dut(peer_line));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    bus <= '0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rdchk(input string what, input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    bus <= '0;
    #1 chk(what, {1'b0, e}, {1'b0, rdata & m});
  endtask
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk("ctrl_b", OFF_CTRL_B, 8'hFF, CTRL_B_RST);
    rdchk("ctrl_c", OFF_CTRL_C, 8'hFF, CTRL_C_RST);
    rdchk("stat_a", OFF_STAT_A, 8'hFF, 8'h20);
    chk("xck_oe", 9'h000, {8'h00, xck_oe});
    chk("tx_oe", 9'h000, {8'h00, serial_out_oe});
  endtask
  // two bytes queued: second leaves no idle gap after the first
  task automatic t_tx_b2b();
    wr(OFF_BAUD_LO, 8'h00);
    wr(OFF_CTRL_B, 8'h28);
    settle();
    chk("irq_udre", 9'h001, {8'h00, irq_udre});
    fork
      begin
        i_usc_peer.recv(d0, p0, s0, w0, 8, 1'b0, 16);
        i_usc_peer.recv(d1, p0, s1, w1, 8, 1'b0, 16);
      end
      begin
        wr(OFF_DATA, 8'hA5);
        repeat (40) @(posedge mclk);
        wr(OFF_DATA, 8'h3C);
      end
    join
    chk("tx0", 9'h0A5, d0);
    chk("tx1", 9'h03C, d1);
    chk("stop", 9'h001, {8'h00, s0 & s1});
    chk("gap", 9'h001, {8'h00, w1 <= 10});
  endtask
  // double speed halves the bit, odd parity inverts the xor
  task automatic t_tx_dbl();
    wr(OFF_STAT_A, 8'h02);
    wr(OFF_CTRL_C, 8'h36);
    fork
      i_usc_peer.recv(d0, p0, s0, w0, 8, 1'b1, 8);
      wr(OFF_DATA, 8'h3C);
    join
    chk("dbl_data", 9'h03C, d0);
    chk("odd_par", {8'h00, ~^8'h3C}, {8'h00, p0});
    wr(OFF_STAT_A, 8'h00);
  endtask
  task automatic t_rx_err();
    wr(OFF_CTRL_C, 8'h26);
    wr(OFF_CTRL_B, 8'hD8);
    i_usc_peer.send(9'h05A, 8, 2'b10, 1'b1, 16);
    chk("irq_rx", 9'h001, {8'h00, irq_rx});
    chk("irq_tx", 9'h001, {8'h00, irq_tx});
    wr(OFF_STAT_A, 8'h40);
    rdchk("rx_ok", OFF_STAT_A, 8'h9C, 8'h80);
    chk("txc_clr", 9'h000, {8'h00, irq_tx});
    rdchk("rx_data", OFF_DATA, 8'hFF, 8'h5A);
    i_usc_peer.send(9'h05A, 8, 2'b11, 1'b1, 16);
    rdchk("rx_pe", OFF_STAT_A, 8'h9C, 8'h84);
    rdchk("pe_data", OFF_DATA, 8'hFF, 8'h5A);
    i_usc_peer.send(9'h0C3, 8, 2'b10, 1'b0, 16);
    rdchk("rx_fe", OFF_STAT_A, 8'h9C, 8'h90);
    rdchk("fe_data", OFF_DATA, 8'hFF, 8'hC3);
  endtask
  // third frame finds the two-deep queue full
  task automatic t_overrun();
    wr(OFF_CTRL_C, 8'h06);
    wr(OFF_PIN_CTRL, 8'h02);
    i_usc_peer.send(9'h011, 8, 2'b00, 1'b1, 16);
    i_usc_peer.send(9'h022, 8, 2'b00, 1'b1, 16);
    i_usc_peer.send(9'h033, 8, 2'b00, 1'b1, 16);
    rdchk("dor", OFF_STAT_A, 8'h9C, 8'h88);
    rdchk("q0", OFF_DATA, 8'hFF, 8'h11);
    rdchk("q1", OFF_DATA, 8'hFF, 8'h22);
    rdchk("sfd", OFF_PIN_CTRL, 8'h06, 8'h06);
  endtask
  task automatic t_sync();
    wr(OFF_CTRL_C, 8'h46);
    wr(OFF_PIN_CTRL, 8'h01);
    settle();
    chk("master_oe", 9'h001, {8'h00, xck_oe});
    p0 = xck_out;
    @(posedge mclk);
    #1 chk("xck_toggle", {8'h00, ~p0}, {8'h00, xck_out});
    wr(OFF_PIN_CTRL, 8'h00);
    settle();
    chk("slave_oe", 9'h000, {8'h00, xck_oe});
    wr(OFF_PIN_CTRL, 8'h01);
    wr(OFF_CTRL_C, 8'h06);
    settle();
    chk("async_oe", 9'h000, {8'h00, xck_oe});
    wr(OFF_PIN_CTRL, 8'h00);
  endtask
  task automatic t_power();
    wr(OFF_POWER, 8'h01);
    settle();
    chk("off_tx_oe", 9'h000, {8'h00, serial_out_oe});
    wr(OFF_POWER, 8'h00);
    settle();
    chk("on_tx_oe", 9'h001, {8'h00, serial_out_oe});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // about 1500 cycles expected; a generous ceiling cuts a hang
  initial begin
    #300000;
    fail_count++;
    complete_run();
  end
  initial begin
    bus = '0;
    sys_rst = 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_tx_b2b();
    t_tx_dbl();
    t_rx_err();
    t_overrun();
    t_sync();
    t_power();
    complete_run();
  end
endmodule
`default_nettype wire
